// File: psq_pkg.sv
// Package: constants and types for the program-counter sequencing block
//
// Summary of operation
// - Every general register is 64 bits wide
// - Reading register index 0 always gives zero
// - Byte order caught at reset from boundary input
// - PC holds current instruction address each slot
// - PC advances by four when nothing writes it
// - Taken branch redirects after its delay slot
// - Delayed results land one slot late
// - Undelayed effects land in their own slot
// - Updates within one instruction keep their order
// - Delayed and next-slot effects have no order
package psq_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int unsigned REGISTER_WIDTH = 64;  // Register and PC width
   localparam int unsigned REG_INDEX_WIDTH = 5;  // 32 general registers
   localparam int unsigned REG_COUNT = 32;
   // ****************************************
   // Values
   // ****************************************
   localparam logic [REGISTER_WIDTH-1:0] PC_STEP = 64'h0000_0000_0000_0004;
   localparam logic [REGISTER_WIDTH-1:0] PC_RESET = 64'h0000_0000_0000_0000;
   localparam logic [REGISTER_WIDTH-1:0] ZERO_WORD = 64'h0000_0000_0000_0000;
   localparam logic [REG_INDEX_WIDTH-1:0] ZERO_INDEX = 5'h00;
   localparam logic ENDIAN_LITTLE = 1'h0;  // 0 selects little-endian
   localparam logic ENDIAN_BIG = 1'h1;     // 1 selects big-endian

   // Redirect tracking for the branch delay slot
   typedef enum logic [0:0] {
      PSQ_SEQ_LINEAR = 1'b0,   // Next slot is PC + 4
      PSQ_SEQ_REDIRECT = 1'b1  // Delay slot running, target pending
   } psq_seq_state_t;
endpackage

// File: psq_regfile.sv
// General register file whose entry 0 is cleared at reset and never written
`timescale 1ns/100ps
module psq_regfile #(
   parameter int unsigned WIDTH = psq_pkg::REGISTER_WIDTH,
   parameter int unsigned COUNT = psq_pkg::REG_COUNT,
   parameter int unsigned IDX_W = psq_pkg::REG_INDEX_WIDTH
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [IDX_W-1:0] rd_a_idx_in,
   output logic [WIDTH-1:0] rd_a_data_out,
   input wire logic [IDX_W-1:0] rd_b_idx_in,
   output logic [WIDTH-1:0] rd_b_data_out,
   input wire logic wr_en_in,
   input wire logic [IDX_W-1:0] wr_idx_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic late_en_in, // Parked result of the previous slot
   input wire logic [IDX_W-1:0] late_idx_in,
   input wire logic [WIDTH-1:0] late_data_in
);
   // ****************************************
   // Storage
   // ****************************************
   logic [WIDTH-1:0] regs [COUNT];  // Full-width entries
   // Index 0 never written, so plain reads give zero
   wire wr_ok = wr_en_in && (wr_idx_in != psq_pkg::ZERO_INDEX);
   wire late_ok = late_en_in && (late_idx_in != psq_pkg::ZERO_INDEX);

   // Write ports; entry 0 cleared at reset and never touched again.
   // The own write comes last, so it wins when both name one entry.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         regs[0] <= psq_pkg::ZERO_WORD;
      end else begin
         if (late_ok) begin
            regs[late_idx_in] <= late_data_in;
         end
         if (wr_ok) begin
            regs[wr_idx_in] <= wr_data_in;
         end
      end
   end

   // Combinational reads; no zero mux needed
   assign rd_a_data_out = regs[rd_a_idx_in];
   assign rd_b_data_out = regs[rd_b_idx_in];

   // ****************************************
   // Checks
   // ****************************************
   a_zero_reg_reads: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_a_idx_in == psq_pkg::ZERO_INDEX |-> rd_a_data_out == psq_pkg::ZERO_WORD)
      else $error("register 0 read nonzero");
   a_zero_reg_b: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_b_idx_in == psq_pkg::ZERO_INDEX |-> rd_b_data_out == psq_pkg::ZERO_WORD)
      else $error("register 0 read nonzero on port b");
   // When both writes name one entry the own write is what remains
   a_own_write_wins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      wr_ok |=> regs[$past(wr_idx_in)] == $past(wr_data_in))
      else $error("own write index lost");
   // A parked result lands unless the own write takes the same entry
   a_late_write_lands: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      late_ok && !(wr_ok && wr_idx_in == late_idx_in)
      |=> regs[$past(late_idx_in)] == $past(late_data_in))
      else $error("delayed write lost");
endmodule

// File: psq_core_seq.sv
// Program-counter sequencing, delay slot, delayed writeback and byte-order latch
`timescale 1ns/100ps
module psq_core_seq #(
   parameter int unsigned WIDTH = psq_pkg::REGISTER_WIDTH,
   parameter int unsigned IDX_W = psq_pkg::REG_INDEX_WIDTH
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic endian_select_in,           // Boundary strap, held during reset
   input wire logic slot_adv_in,                // One instruction slot completes
   input wire logic pc_write_in,                // Instruction writes PC directly (jump)
   input wire logic [WIDTH-1:0] pc_write_val_in,
   input wire logic branch_taken_in,            // Taken branch in this slot
   input wire logic [WIDTH-1:0] branch_target_in,
   input wire logic wr_now_in,                  // Undelayed destination write
   input wire logic wr_delayed_in,              // Result lands one slot late
   input wire logic [IDX_W-1:0] wr_idx_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [IDX_W-1:0] rd_a_idx_in,
   input wire logic [IDX_W-1:0] rd_b_idx_in,
   output logic [WIDTH-1:0] pc_out,             // Address of current slot's instruction
   output logic endian_big_out,                 // Latched byte order
   output logic in_delay_slot_out,              // Current slot is a delay slot
   output logic [WIDTH-1:0] rd_a_data_out,
   output logic [WIDTH-1:0] rd_b_data_out
);
   // ****************************************
   // State
   // ****************************************
   // Sequencing state; all of it moves only on a slot edge
   logic [WIDTH-1:0] pc; // Current instruction address
   logic [WIDTH-1:0] target; // Branch target captured with the branch
   psq_pkg::psq_seq_state_t seq; // Delay-slot tracking
   // Delayed result parked between its own slot and the next one
   logic dly_pend; // Delayed write waiting one slot
   logic [IDX_W-1:0] dly_idx; // Destination of the parked result
   logic [WIDTH-1:0] dly_data; // Value of the parked result
   // Byte order, sampled while reset is held
   logic endian_big; // Byte order, fixed after reset
   // Register file read ports and their output flops
   logic [WIDTH-1:0] rf_a; // Port A, combinational
   logic [WIDTH-1:0] rf_b; // Port B, combinational
   logic [WIDTH-1:0] a_q; // Port A, registered
   logic [WIDTH-1:0] b_q; // Port B, registered

   // ****************************************
   // Next-PC selection
   // ****************************************
   // Priority: direct write, then pending branch target, else PC + 4.
   // A jump inside a delay slot therefore overrides the earlier branch;
   // software is not expected to do this, but the result is defined.
   // The step wraps at the top of the address space rather than trapping;
   // address checks belong to the fetch side, not to this block.
   wire redirect = (seq == psq_pkg::PSQ_SEQ_REDIRECT);
   wire [WIDTH-1:0] pc_plus = pc + psq_pkg::PC_STEP;
   wire [WIDTH-1:0] next_pc = pc_write_in ? pc_write_val_in :
                              redirect ? target : pc_plus;
   // A branch sitting in a delay slot arms a fresh redirect for the slot
   // after it, so back-to-back branches each get their own delay slot
   wire psq_pkg::psq_seq_state_t next_seq =
      branch_taken_in ? psq_pkg::PSQ_SEQ_REDIRECT : psq_pkg::PSQ_SEQ_LINEAR;

   // ****************************************
   // Register write arbitration
   // ****************************************
   // The delayed write of the previous slot and this slot's own write land
   // on the same edge through two write ports, so neither is lost when the
   // destinations differ. When both name one register the own write is
   // applied last and stays visible; software may not rely on either order.
   // Both strobes are gated by the slot edge: a stalled slot writes nothing.
   wire own_wr = slot_adv_in && wr_now_in;
   wire late_wr = slot_adv_in && dly_pend;

   // Own result on the first write port, parked result on the second
   psq_regfile #(
      .WIDTH(WIDTH),
      .COUNT(psq_pkg::REG_COUNT),
      .IDX_W(IDX_W)
   ) u_regs (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .rd_a_idx_in(rd_a_idx_in),
      .rd_a_data_out(rf_a),
      .rd_b_idx_in(rd_b_idx_in),
      .rd_b_data_out(rf_b),
      .wr_en_in(own_wr),
      .wr_idx_in(wr_idx_in),
      .wr_data_in(wr_data_in),
      .late_en_in(late_wr),
      .late_idx_in(dly_idx),
      .late_data_in(dly_data)
   );

   // ****************************************
   // Processes
   // ****************************************
   // Byte order: held by reset, so the value seen on release is kept.
   // The strap is sampled on every reset cycle, so a strap that settles
   // late in reset is still picked up; after release it is ignored, which
   // keeps a noisy strap pin from flipping byte order mid-run.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         endian_big <= endian_select_in;
      end
   end

   // PC and delay-slot state step once per slot.
   // Between slot edges everything holds, so a stalled slot keeps pointing
   // at its own instruction. The target is captured on every slot; it is
   // only used when the slot edge also arms the redirect.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pc <= psq_pkg::PC_RESET;
         seq <= psq_pkg::PSQ_SEQ_LINEAR;
         target <= psq_pkg::ZERO_WORD;
      end else if (slot_adv_in) begin
         pc <= next_pc;
         seq <= next_seq;
         target <= branch_target_in;
      end
   end

   // Delayed result parked for exactly one slot.
   // Index and data carry no reset: they are only read while dly_pend is
   // set, and leaving them out of reset keeps the wide data path cheap.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         dly_pend <= 1'b0;
      end else if (slot_adv_in) begin
         dly_pend <= wr_delayed_in;
         dly_idx <= wr_idx_in;
         dly_data <= wr_data_in;
      end
   end

   // Registered read data so outputs come from flip-flops.
   // The price is one cycle of read latency after the index changes.
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         a_q <= psq_pkg::ZERO_WORD;
         b_q <= psq_pkg::ZERO_WORD;
      end else begin
         a_q <= rf_a;
         b_q <= rf_b;
      end
   end

   // Outputs, each taken from a flop
   assign pc_out = pc;
   assign endian_big_out = endian_big;
   assign in_delay_slot_out = redirect;
   assign rd_a_data_out = a_q;
   assign rd_b_data_out = b_q;

   // ****************************************
   // Checks
   // ****************************************
   // Sequencing checks look one edge after the slot that moved the state;
   // reset cycles are left out except where reset itself is the subject.
   // Plain slot with nothing redirecting: step of four
   a_pc_step_four: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && !pc_write_in && !redirect |=> pc == $past(pc) + psq_pkg::PC_STEP)
      else $error("pc did not advance by four");
   // The branch itself still steps by four, so the delay slot runs next
   a_delay_slot_go: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && branch_taken_in && !pc_write_in && !redirect
      |=> pc == $past(pc) + psq_pkg::PC_STEP)
      else $error("delay slot skipped");
   // The delay slot's own edge loads the target captured with the branch
   a_branch_target: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && redirect && !pc_write_in |=> pc == $past(target))
      else $error("branch target not loaded");
   // No slot edge, no movement of the program counter
   a_pc_hold_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !slot_adv_in |=> $stable(pc))
      else $error("pc moved within a slot");
   // A direct write is seen by the very next slot
   a_jump_now: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && pc_write_in |=> pc == $past(pc_write_val_in))
      else $error("direct pc write lost");
   // Byte order may only move while reset is held
   a_endian_fixed: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $stable(endian_big))
      else $error("byte order changed after reset");
   // Each reset cycle takes the strap as it stood at that edge
   a_endian_strap: assert property (@(posedge clock_in)
      sys_rst_in |=> endian_big == $past(endian_select_in))
      else $error("byte order not taken from strap");
   // Reset leaves a plain sequence at address zero with nothing parked
   a_reset_pc: assert property (@(posedge clock_in)
      sys_rst_in |=> pc == psq_pkg::PC_RESET && !redirect && !dly_pend)
      else $error("reset state wrong");
   // The branch target is captured on the branch's own slot edge
   a_target_capture: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && branch_taken_in |=> target == $past(branch_target_in))
      else $error("branch target not captured");
   // The delay-slot flag marks exactly the slot after a taken branch
   a_slot_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && branch_taken_in |=> in_delay_slot_out)
      else $error("delay slot not flagged");
   a_slot_flag_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && !branch_taken_in |=> !in_delay_slot_out)
      else $error("delay slot flag left set");
   // A delayed result is parked on its own slot edge
   a_delay_one_slot: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && wr_delayed_in |=> dly_pend)
      else $error("delayed write not parked");
   // Parked for one slot only, and a stalled slot keeps it parked
   a_pend_clears: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      slot_adv_in && !wr_delayed_in |=> !dly_pend)
      else $error("delayed write parked too long");
   a_pend_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !slot_adv_in |=> $stable(dly_pend))
      else $error("delayed write moved without a slot");
   // Index 0 reads as zero at both registered outputs
   a_zero_out_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_a_idx_in == psq_pkg::ZERO_INDEX |=> rd_a_data_out == psq_pkg::ZERO_WORD)
      else $error("port a read of register 0 nonzero");
   a_zero_out_b: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_b_idx_in == psq_pkg::ZERO_INDEX |=> rd_b_data_out == psq_pkg::ZERO_WORD)
      else $error("port b read of register 0 nonzero");
endmodule

// File: psq_core_seq_tb.sv
// Self-checking testbench for the program-counter sequencing block
`timescale 1ns/100ps
module psq_core_seq_tb;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic endian_select_in = 1'b1;
   logic slot_adv_in = 1'b0;
   logic pc_write_in = 1'b0;
   logic [63:0] pc_write_val_in = 64'h0000_0000_0000_2000; // Jump destination
   logic branch_taken_in = 1'b0;
   logic [63:0] branch_target_in = 64'h0000_0000_0000_1000; // Branch target
   logic wr_now_in = 1'b0;
   logic wr_delayed_in = 1'b0;
   logic [4:0] wr_idx_in = 5'h00;
   logic [63:0] wr_data_in = 64'h0;
   logic [4:0] rd_a_idx_in = 5'h00;
   logic [4:0] rd_b_idx_in = 5'h00;
   logic [63:0] pc_out, rd_a_data_out, rd_b_data_out;
   logic endian_big_out, in_delay_slot_out;
   int err_total = 0;
   int cmp_count = 0;
   localparam logic [63:0] TGT = 64'h0000_0000_0000_1000;
   localparam logic [63:0] JMP = 64'h0000_0000_0000_2000;
   localparam logic [63:0] VA = 64'h8877_6655_4433_2211; // Upper bits set: full width
   localparam logic [63:0] VD = 64'h0123_4567_89ab_cdef;
   always #2.5 clock_in = ~clock_in; // 200 MHz
   psq_core_seq psq_core_seq_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .endian_select_in(endian_select_in), .slot_adv_in(slot_adv_in),
      .pc_write_in(pc_write_in), .pc_write_val_in(pc_write_val_in),
      .branch_taken_in(branch_taken_in), .branch_target_in(branch_target_in),
      .wr_now_in(wr_now_in), .wr_delayed_in(wr_delayed_in), .wr_idx_in(wr_idx_in),
      .wr_data_in(wr_data_in), .rd_a_idx_in(rd_a_idx_in), .rd_b_idx_in(rd_b_idx_in),
      .pc_out(pc_out), .endian_big_out(endian_big_out),
      .in_delay_slot_out(in_delay_slot_out), .rd_a_data_out(rd_a_data_out),
      .rd_b_data_out(rd_b_data_out));
   // ****************************************
   // Shared tasks
   // ****************************************
   task check(input string n, input logic [63:0] s, input logic [63:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Drive one slot's inputs; judge the state left by the previous slot
   task step(input logic a, pw, bt, wn, wd, input logic [4:0] ix, input logic [63:0] d,
             input logic [63:0] epc, input logic eds);
      @(posedge clock_in);
      slot_adv_in <= a;
      pc_write_in <= pw;
      branch_taken_in <= bt;
      wr_now_in <= wn;
      wr_delayed_in <= wd;
      wr_idx_in <= ix;
      wr_data_in <= d;
      #1;
      check("pc", pc_out, epc);
      check("delay_slot", {63'h0, in_delay_slot_out}, {63'h0, eds});
   endtask
   // Read one index on both ports; held long enough for the registered read
   task rd(input logic [4:0] ix, input logic [63:0] e);
      @(posedge clock_in);
      rd_a_idx_in <= ix;
      rd_b_idx_in <= ix;
      repeat (2) @(posedge clock_in);
      #1;
      check("rd_a", rd_a_data_out, e);
      check("rd_b", rd_b_data_out, e);
   endtask
   // Reset with a strap value, held 16 cycles; strap kept after release
   task do_reset(input logic v);
      @(posedge clock_in);
      sys_rst_in <= 1'b1;
      endian_select_in <= v;
      slot_adv_in <= 1'b0;
      repeat (16) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      #1;
      check("endian", {63'h0, endian_big_out}, {63'h0, v});
      check("pc_reset", pc_out, 64'h0);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_linear(); // Plus four per slot, hold while no slot ends
      step(1, 0, 0, 0, 0, 0, 0, 64'h0, 0);
      step(1, 0, 0, 0, 0, 0, 0, 64'h4, 0);
      step(1, 0, 0, 0, 0, 0, 0, 64'h8, 0);
      step(0, 0, 0, 0, 0, 0, 0, 64'hc, 0);
      step(0, 0, 0, 0, 0, 0, 0, 64'hc, 0);
   endtask
   task t_branch(); // Delay slot runs at PC+4, target follows
      step(1, 0, 1, 0, 0, 0, 0, 64'hc, 0);
      step(1, 0, 0, 0, 0, 0, 0, 64'h10, 1);
      step(0, 0, 0, 0, 0, 0, 0, TGT, 0);
   endtask
   task t_jump(); // Direct write takes effect at once, no delay slot
      step(1, 1, 0, 0, 0, 0, 0, TGT, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP, 0);
   endtask
   task t_writes(); // Delayed result must wait for the next slot
      step(1, 0, 0, 1, 0, 5'h05, VA, JMP, 0);
      step(1, 0, 0, 0, 1, 5'h05, VD, JMP + 4, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP + 8, 0);
      rd(5'h05, VA);
      step(1, 0, 0, 0, 0, 0, 0, JMP + 8, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP + 12, 0);
      rd(5'h05, VD);
   endtask
   task t_zero(); // Both write kinds aimed at index 0 are dropped
      step(1, 0, 0, 1, 0, 5'h00, '1, JMP + 12, 0);
      step(1, 0, 0, 0, 1, 5'h00, '1, JMP + 16, 0);
      step(1, 0, 0, 0, 0, 0, 0, JMP + 20, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP + 24, 0);
      rd(5'h00, 64'h0);
   endtask
   task t_collide(); // Delayed and own writes meet in one slot
      step(1, 0, 0, 0, 1, 5'h06, VA, JMP + 24, 0);
      step(1, 0, 0, 1, 0, 5'h07, VD, JMP + 28, 0);
      step(1, 0, 0, 0, 1, 5'h08, VA, JMP + 32, 0);
      step(1, 0, 0, 1, 0, 5'h08, VD, JMP + 36, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP + 40, 0);
      rd(5'h06, VA);
      rd(5'h07, VD);
      rd(5'h08, VD);
   endtask
   task t_restart(); // Reset inside a delay slot drops the pending redirect
      step(1, 0, 1, 0, 0, 0, 0, JMP + 40, 0);
      step(0, 0, 0, 0, 0, 0, 0, JMP + 44, 1);
      do_reset(1'b0); // Mid-run reset picks up the new strap
      step(1, 0, 0, 0, 0, 0, 0, 64'h0, 0);
      step(0, 0, 0, 0, 0, 0, 0, 64'h4, 0);
   endtask
   task give_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog: the whole run needs well under 500 cycles
   initial begin
      repeat (2000) @(posedge clock_in);
      err_total++;
      give_verdict();
   end
   initial begin
      do_reset(1'b1);
      t_linear();
      t_branch();
      t_jump();
      t_writes();
      t_zero();
      t_collide();
      t_restart();
      give_verdict();
   end
endmodule
